// [rtl/scas_pkg.sv]
/*
   Shared constants and types of the smart card activation sequencer.
   Assumes a single 40 MHz clock and a synchronous active-high reset.
*/
package scas_pkg;
   // -----------------------------------------------------------------
   // Sequencer and channel states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SCAS_IDLE   = 2'h0,
      SCAS_ACTIVE = 2'h1,
      SCAS_FAULT  = 2'h3,
      SCAS_ALARM  = 2'h2
   } scas_state_e;

   typedef enum logic [1:0] {
      SCAS_CH_IDLE = 2'h0,
      SCAS_CH_H2C  = 2'h1,
      SCAS_CH_REL  = 2'h3,
      SCAS_CH_C2H  = 2'h2
   } scas_chan_e;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned SCAS_CLK_PERIOD_NS = 25;
   localparam int unsigned SCAS_FAULT_LIMIT_NS = 5000;
   localparam int unsigned SCAS_FAULT_CYC =
      (SCAS_FAULT_LIMIT_NS + SCAS_CLK_PERIOD_NS - 1) / SCAS_CLK_PERIOD_NS;
   localparam int unsigned SCAS_FAULT_CNT_W = 8;

   // -----------------------------------------------------------------
   // Pin levels and reset values
   // -----------------------------------------------------------------
   localparam logic SCAS_LOW = 1'h0;
   localparam logic SCAS_HIGH = 1'h1;
   localparam logic SCAS_DRIVE_N = 1'h0;
   localparam logic SCAS_RELEASE_N = 1'h1;
   localparam int unsigned SCAS_NUM_CHAN = 3;
endpackage

// [rtl/scas_ctl_if.sv]
/*
   Control bundle from the sequencer to its fault timer and channels.
   Assumes all members are on clk_in of the sequencer.
*/
interface scas_ctl_if;
   logic fault_run;
   logic fault_expired;
   logic chan_en;
   logic shut;

   modport seq (output fault_run, output chan_en, output shut, input fault_expired);
   modport tmr (input fault_run, output fault_expired);
   modport chan (input chan_en, input shut);
endinterface

// [rtl/scas_ftmr.sv]
/*
   Fault duration timer: counts cycles while a fault persists in the
   fault timeout state. Assumes run drops as soon as the fault ends.
*/
module scas_ftmr
   import scas_pkg::*;
#(
   parameter int unsigned LIMIT = SCAS_FAULT_CYC,
   parameter int unsigned CNT_W = SCAS_FAULT_CNT_W
) (
   input wire logic clk_in,
   input wire logic srst_in,
   scas_ctl_if.tmr ctl
);
   localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);
   localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
   localparam logic [CNT_W-1:0] ZERO = '0;

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;

   // -----------------------------------------------------------------
   // Saturating duration counter
   // -----------------------------------------------------------------
   assign next_cnt = !ctl.fault_run ? ZERO : (cnt == LIM) ? cnt : cnt + ONE;

   // Counter and expiry flag
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cnt <= ZERO;
         ctl.fault_expired <= SCAS_LOW;
      end else begin
         cnt <= next_cnt;
         ctl.fault_expired <= ctl.fault_run && (next_cnt == LIM);
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);

   tmr_clear_a: assert property (!ctl.fault_run |=> !ctl.fault_expired)
      else $error("fault timer expired without a running fault");
endmodule

// [rtl/scas_chan.sv]
/*
   One bidirectional channel between a host-side and a card-side line.
   Both lines are open drain with external or dynamic pull-ups; the
   output enables are active low. Inputs are synchronous to clk_in.
*/
module scas_chan
   import scas_pkg::*;
(
   input wire logic clk_in,
   input wire logic srst_in,
   scas_ctl_if.chan ctl,
   input wire logic host_in,
   input wire logic card_in,
   output logic host_out,
   output logic host_oe_n_out,
   output logic card_out,
   output logic card_oe_n_out,
   output logic collision_out
);
   scas_chan_e state;
   scas_chan_e next_state;
   logic next_host_drv;
   logic next_card_drv;
   logic next_coll;

   // -----------------------------------------------------------------
   // Direction tracking: first side low is master
   // -----------------------------------------------------------------
   always_comb begin
      next_state = state;
      if (!ctl.chan_en) begin
         next_state = SCAS_CH_IDLE;
      end else begin
         case (state)
            SCAS_CH_IDLE: begin
               if (!host_in) begin
                  next_state = SCAS_CH_H2C;
               end else if (!card_in) begin
                  next_state = SCAS_CH_C2H;
               end
            end
            SCAS_CH_H2C: begin
               if (host_in) begin
                  next_state = SCAS_CH_REL;
               end
            end
            SCAS_CH_C2H: begin
               if (card_in) begin
                  next_state = SCAS_CH_REL;
               end
            end
            SCAS_CH_REL: begin
               if (host_in && card_in) begin
                  next_state = SCAS_CH_IDLE;
               end
            end
            default: next_state = SCAS_CH_IDLE;
         endcase
      end
   end

   // Drive decisions; a low imposed by the slave is never sent back
   assign next_card_drv = ctl.chan_en ? (next_state == SCAS_CH_H2C) : SCAS_HIGH;
   assign next_host_drv = ctl.chan_en ? (next_state == SCAS_CH_C2H) : ctl.shut;
   assign next_coll = ctl.chan_en && (state == SCAS_CH_REL) && !(host_in && card_in);

   // State and registered pin drivers
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state <= SCAS_CH_IDLE;
         host_out <= SCAS_LOW;
         card_out <= SCAS_LOW;
         host_oe_n_out <= SCAS_RELEASE_N;
         card_oe_n_out <= SCAS_DRIVE_N;
         collision_out <= SCAS_LOW;
      end else begin
         state <= next_state;
         host_out <= SCAS_LOW;
         card_out <= SCAS_LOW;
         host_oe_n_out <= next_host_drv ? SCAS_DRIVE_N : SCAS_RELEASE_N;
         card_oe_n_out <= next_card_drv ? SCAS_DRIVE_N : SCAS_RELEASE_N;
         collision_out <= next_coll;
      end
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);

   chan_collide_a: assert property (
      (ctl.chan_en && state == SCAS_CH_H2C && host_in) ##1 (ctl.chan_en && !card_in) |=> collision_out)
      else $error("collision after host release not flagged");
   chan_shut_a: assert property ((!ctl.chan_en && ctl.shut) |=> !host_oe_n_out)
      else $error("host side not pulled low during shutdown");
   chan_noecho_a: assert property ((state == SCAS_CH_H2C) |-> host_oe_n_out)
      else $error("card low echoed back to host master");
endmodule

// [rtl/scas_top.sv]
/*
   Activation sequencer of a smart card interface: powers the card,
   passes host reset and clock, self-starts on request low, deactivates on
   request or fault, times faults and reports alarms and overtemperature.
   Assumes analog comparators supply overtemperature, fault, supply-ready
   and supply-discharged levels synchronous to clk_in; bidirectional
   lines are resolved outside from the active-low output enables.
*/
// Notes on behaviour
// - Overtemperature disables device and raises alarm
// - Request low starts activation, card present or not
// - Ready low when card supply is final
// - Card stays powered while presence holds
// - Card removal counts as fault, deactivates
// - Request high runs the deactivation sequence
// - Fault past the limit runs deactivation without host
// - Idle drives supply and card lines low
// - Idle releases ready, alarm, host lines
// - Idle lasts until supply has discharged
// - Activation ignored until discharge complete
// - Alarm state is idle plus alarm low
// - Alarm leaves only to idle, request high
// - Alarm cleared by toggle, activation still waits
// - Active supply level follows captured selection
// - Data lines carry data after ready low
// - Fault longer than limit enters alarm
// - Short fault returns to active state
// - Either side low after master release is collision
// - Shutdown pulls host side channel low
// - Supply level latched on request falling edge
module scas_top
   import scas_pkg::*;
#(
   parameter int unsigned FAULT_CYC = SCAS_FAULT_CYC,
   parameter int unsigned NUM_CHAN = SCAS_NUM_CHAN
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic activation_request_n_in,
   input wire logic presence_sense_in,
   input wire logic switch_polarity_select_in,
   input wire logic supply_level_select_in,
   input wire logic host_reset_input_in,
   input wire logic host_clock_input_in,
   input wire logic overtemp_in,
   input wire logic supply_fault_in,
   input wire logic supply_final_in,
   input wire logic supply_discharged_in,
   input wire logic [NUM_CHAN-1:0] host_line_in,
   input wire logic [NUM_CHAN-1:0] card_line_in,
   output logic [NUM_CHAN-1:0] host_line_out,
   output logic [NUM_CHAN-1:0] host_line_oe_n_out,
   output logic [NUM_CHAN-1:0] card_line_out,
   output logic [NUM_CHAN-1:0] card_line_oe_n_out,
   output logic [NUM_CHAN-1:0] collision_out,
   output logic supply_enable_out,
   output logic supply_level_high_out,
   output logic card_reset_out,
   output logic card_clock_out,
   output logic ready_n_out,
   output logic ready_oe_n_out,
   output logic alarm_n_out,
   output logic alarm_oe_n_out,
   output logic presence_flag_n_out
);
   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   scas_ctl_if ctl ();

   scas_state_e state;
   scas_state_e next_state;
   logic discharged;
   logic next_discharged;
   logic level_high;
   logic next_level_high;
   logic req_prev;
   logic req_fall;
   logic card_present;
   logic fault_cause;
   logic act_next;
   logic act_now;
   logic alarm_next;

   // True in the states where the card is powered
   function automatic logic scas_powered(input scas_state_e s);
      return (s == SCAS_ACTIVE) || (s == SCAS_FAULT);
   endfunction

   // -----------------------------------------------------------------
   // Event decoding
   // -----------------------------------------------------------------
   // Presence flag is active low; card present when flag is low
   assign card_present = !(presence_sense_in ^ switch_polarity_select_in);
   assign fault_cause = supply_fault_in || !card_present;
   assign req_fall = req_prev && !activation_request_n_in;
   assign act_next = scas_powered(next_state);
   assign act_now = scas_powered(state);
   assign alarm_next = (next_state == SCAS_ALARM);

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   always_comb begin
      next_state = state;
      if (overtemp_in) begin
         next_state = SCAS_ALARM;
      end else begin
         case (state)
            SCAS_IDLE: begin
               if (!activation_request_n_in && discharged) begin
                  next_state = SCAS_ACTIVE;
               end
            end
            SCAS_ACTIVE: begin
               if (activation_request_n_in) begin
                  next_state = SCAS_IDLE;
               end else if (fault_cause) begin
                  next_state = SCAS_FAULT;
               end
            end
            SCAS_FAULT: begin
               if (activation_request_n_in) begin
                  next_state = SCAS_IDLE;
               end else if (!fault_cause) begin
                  next_state = SCAS_ACTIVE;
               end else if (ctl.fault_expired) begin
                  next_state = SCAS_ALARM;
               end
            end
            SCAS_ALARM: begin
               if (activation_request_n_in) begin
                  next_state = SCAS_IDLE;
               end
            end
            default: next_state = SCAS_IDLE;
         endcase
      end
   end

   // Discharge completion holds only while idle; re-armed on each entry
   assign next_discharged = (next_state == SCAS_IDLE) &&
      (discharged || supply_discharged_in);

   // Supply level latched on the request's falling edge only
   assign next_level_high = req_fall ? supply_level_select_in : level_high;

   // Timer and channel controls
   assign ctl.fault_run = (state == SCAS_FAULT) && fault_cause;
   // Enable follows the next state so the card lines drop low with the supply
   assign ctl.chan_en = act_next && !ready_n_out;
   assign ctl.shut = overtemp_in;

   // State and latches
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state <= SCAS_IDLE;
         discharged <= SCAS_LOW;
         level_high <= SCAS_LOW;
         req_prev <= SCAS_HIGH;
      end else begin
         state <= next_state;
         discharged <= next_discharged;
         level_high <= next_level_high;
         req_prev <= activation_request_n_in;
      end
   end

   // -----------------------------------------------------------------
   // Registered pin drivers, decoded from the next state except the presence flag and the supply level
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         supply_enable_out <= SCAS_LOW;
         supply_level_high_out <= SCAS_LOW;
         card_reset_out <= SCAS_LOW;
         card_clock_out <= SCAS_LOW;
         ready_n_out <= SCAS_HIGH;
         ready_oe_n_out <= SCAS_RELEASE_N;
         alarm_n_out <= SCAS_HIGH;
         alarm_oe_n_out <= SCAS_RELEASE_N;
         presence_flag_n_out <= SCAS_HIGH;
      end else begin
         supply_enable_out <= act_next;
         supply_level_high_out <= next_level_high;
         card_reset_out <= act_next && host_reset_input_in;
         card_clock_out <= act_next && host_clock_input_in;
         ready_n_out <= !(act_next && supply_final_in);
         ready_oe_n_out <= act_next ? SCAS_DRIVE_N : SCAS_RELEASE_N;
         alarm_n_out <= !alarm_next;
         alarm_oe_n_out <= (act_next || alarm_next) ? SCAS_DRIVE_N : SCAS_RELEASE_N;
         presence_flag_n_out <= presence_sense_in ^ switch_polarity_select_in;
      end
   end

   // -----------------------------------------------------------------
   // Fault timer and bidirectional channels
   // -----------------------------------------------------------------
   scas_ftmr #(
      .LIMIT(FAULT_CYC),
      .CNT_W(SCAS_FAULT_CNT_W)
   ) u_ftmr (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .ctl(ctl)
   );

   // Index 0 data to card I/O, 1 and 2 the auxiliary pairs
   for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
      scas_chan u_chan (
         .clk_in(clk_in),
         .srst_in(srst_in),
         .ctl(ctl),
         .host_in(host_line_in[i]),
         .card_in(card_line_in[i]),
         .host_out(host_line_out[i]),
         .host_oe_n_out(host_line_oe_n_out[i]),
         .card_out(card_line_out[i]),
         .card_oe_n_out(card_line_oe_n_out[i]),
         .collision_out(collision_out[i])
      );
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   localparam int FMAX = 210;

   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);

   sequence s_idle_ready;
      state == SCAS_IDLE && discharged && !overtemp_in;
   endsequence

   sequence s_request_low;
      !activation_request_n_in;
   endsequence

   overtemp_alarm_a: assert property (overtemp_in |=> (!alarm_n_out && !alarm_oe_n_out && !supply_enable_out))
      else $error("overtemperature did not disable and alarm");
   self_start_a: assert property ((s_idle_ready ##0 s_request_low) |=> (supply_enable_out && state == SCAS_ACTIVE))
      else $error("activation not started on request");
   ready_final_a: assert property ((act_now && $past(act_now) && $past(supply_final_in)) |-> !ready_n_out)
      else $error("ready not low with final supply");
   discharge_hold_a: assert property ((state == SCAS_IDLE && !discharged && !supply_discharged_in) |=> !supply_enable_out)
      else $error("activation before discharge complete");
   idle_pins_a: assert property ((state == SCAS_IDLE) |-> (!supply_enable_out && !card_reset_out && !card_clock_out
      && card_line_oe_n_out == '0 && alarm_oe_n_out && ready_oe_n_out))
      else $error("idle pins not in deactivated levels");
   deact_req_a: assert property ((act_now && activation_request_n_in && !overtemp_in) |=> state == SCAS_IDLE)
      else $error("request high did not deactivate");
   alarm_stay_a: assert property ((state == SCAS_ALARM && !activation_request_n_in) |=> state == SCAS_ALARM)
      else $error("alarm left without request high");
   fault_bound_a: assert property ((state == SCAS_FAULT && fault_cause && !activation_request_n_in)
      |-> ##[1:FMAX] state != SCAS_FAULT)
      else $error("fault timeout not resolved in time");
   fault_short_a: assert property ((state == SCAS_FAULT && !fault_cause && !overtemp_in && !activation_request_n_in)
      |=> state == SCAS_ACTIVE)
      else $error("short fault did not return to active");
   level_latch_a: assert property ((!req_prev && !activation_request_n_in) |=> $stable(supply_level_high_out))
      else $error("supply level changed while request low");
   pass_reset_a: assert property (($past(act_now) && act_now && !overtemp_in)
      |-> card_reset_out == $past(host_reset_input_in, 1))
      else $error("card reset does not follow host reset");
   data_gate_a: assert property (ready_n_out |=> card_line_oe_n_out == '0)
      else $error("card lines released before ready");
endmodule

// [test/scas_far_model.sv]
/*
   Far-side model: card supply capacitor and pulled-up open-drain lines.
   Assumes active-low line enables and supply enable from the sequencer.
*/
module scas_far_model
   import scas_pkg::*;
#(
   parameter int unsigned RISE = 3,
   parameter int unsigned FALL = 8
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic supply_enable_in,
   input wire logic [2:0] host_oe_n_in,
   input wire logic [2:0] card_oe_n_in,
   input wire logic [2:0] host_pull_in,
   input wire logic [2:0] card_pull_in,
   output logic supply_final_out,
   output logic supply_discharged_out,
   output logic [2:0] host_line_out,
   output logic [2:0] card_line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] on_cnt;
   logic [3:0] off_cnt;
   // -----------------------------------------------------------------
   // Supply ramp and discharge
   // -----------------------------------------------------------------
   // Supply reaches final value after RISE cycles, discharges after FALL
   always_ff @(posedge clk_in) begin
      on_cnt <= (srst_in || !supply_enable_in) ? 4'h0 : on_cnt + 4'(on_cnt != 4'hf);
      off_cnt <= (srst_in || supply_enable_in) ? 4'h0 : off_cnt + 4'(off_cnt != 4'hf);
   end
   assign supply_final_out = on_cnt >= RISE;
   assign supply_discharged_out = off_cnt >= FALL;
   // -----------------------------------------------------------------
   // Wired lines
   // -----------------------------------------------------------------
   // A released line goes to its pull-up level
   assign host_line_out = host_oe_n_in & ~host_pull_in;
   assign card_line_out = card_oe_n_in & ~card_pull_in;
endmodule

// [test/smart_card_activation_sequencer_tb.sv]
/*
   Self-checking bench of the activation sequencer.
   Assumes scas_top with a short fault limit and the far-side model.
*/
module smart_card_activation_sequencer_tb;
   import scas_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, srst_in = 1, req_n = 1, presence_sense = 0, pol = 0, lvl = 0;
   logic host_reset_input = 0, host_clock_input = 0, ot = 0, flt = 0, fin, dis;
   logic [2:0] hpull = 0, cpull = 0, hl, cl, hoe, coe, col, hdo, cdo;
   logic sup, lvh, crst, cclk, rdy, rdy_oe, alm, alm_oe, flag;
   int miscompares = 0, cmp_count = 0;
   // Clock at 40 MHz
   initial forever #12.5 clk_in = ~clk_in;
   scas_top #(.FAULT_CYC(4), .NUM_CHAN(3)) u_scas_top (.clk_in(clk_in), .srst_in(srst_in),
      .activation_request_n_in(req_n), .presence_sense_in(presence_sense), .switch_polarity_select_in(pol),
      .supply_level_select_in(lvl), .host_reset_input_in(host_reset_input), .host_clock_input_in(host_clock_input),
      .overtemp_in(ot), .supply_fault_in(flt), .supply_final_in(fin), .supply_discharged_in(dis),
      .host_line_in(hl), .card_line_in(cl), .host_line_out(hdo), .host_line_oe_n_out(hoe),
      .card_line_out(cdo), .card_line_oe_n_out(coe), .collision_out(col), .supply_enable_out(sup),
      .supply_level_high_out(lvh), .card_reset_out(crst), .card_clock_out(cclk), .ready_n_out(rdy),
      .ready_oe_n_out(rdy_oe), .alarm_n_out(alm), .alarm_oe_n_out(alm_oe), .presence_flag_n_out(flag));
   scas_far_model u_scas_far_model (.clk_in(clk_in), .srst_in(srst_in), .supply_enable_in(sup),
      .host_oe_n_in(hoe), .card_oe_n_in(coe), .host_pull_in(hpull), .card_pull_in(cpull),
      .supply_final_out(fin), .supply_discharged_out(dis), .host_line_out(hl), .card_line_out(cl));
   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // Request activation and wait for ready under a bound
   task automatic activate();
      req_n = 0;
      for (int i = 0; i < 20 && rdy !== 1'h0; i++) step(1);
      chk("ready", 3'h0, {2'h0, rdy});
      step(1);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_idle();
      chk("supply", 3'h0, {2'h0, sup});
      chk("card oe", 3'h0, coe);
      chk("host oe", 3'h7, hoe);
      chk("rdy alm oe", 3'h3, {1'h0, rdy_oe, alm_oe});
      chk("line out", 3'h0, hdo | cdo);
      chk("idle rst clk col", 3'h0, {crst, cclk, |col});
      $display("idle test done");
   endtask
   task automatic t_active();
      lvl = 1;
      activate();
      lvl = 0;
      host_reset_input = 1;
      host_clock_input = 1;
      step(3);
      chk("supply level", 3'h1, {2'h0, lvh});
      chk("rst clk alarm", 3'h7, {crst, cclk, alm});
      chk("flag", 3'h0, {2'h0, flag});
      $display("active test done");
   endtask
   task automatic t_chan();
      hpull = 3'h1;
      step(3);
      chk("card oe", 3'h6, coe);
      hpull = 3'h0;
      cpull = 3'h1;
      step(4);
      chk("collision", 3'h1, col);
      chk("host oe", 3'h7, hoe);
      cpull = 3'h0;
      step(4);
      chk("collision", 3'h0, col);
      $display("channel test done");
   endtask
   task automatic t_fault();
      flt = 1;
      step(2);
      flt = 0;
      step(3);
      chk("short fault", 3'h3, {1'h0, sup, alm});
      flt = 1;
      step(10);
      chk("alarm", 3'h0, {sup, alm, alm_oe});
      chk("card oe", 3'h0, coe);
      flt = 0;
      step(3);
      chk("alarm held", 3'h0, {2'h0, alm});
      req_n = 1;
      step(3);
      chk("alarm oe", 3'h1, {2'h0, alm_oe});
      $display("fault test done");
   endtask
   task automatic t_deact();
      activate();
      host_reset_input = 0;
      host_clock_input = 0;
      step(1);
      req_n = 1;
      step(2);
      chk("deact", 3'h1, {1'h0, sup, rdy_oe});
      req_n = 0;
      step(3);
      chk("early act", 3'h0, {2'h0, sup});
      step(12);
      chk("late act", 3'h1, {2'h0, sup});
      $display("deactivation test done");
   endtask
   task automatic t_removal();
      activate();
      presence_sense = 1;
      step(2);
      chk("flag", 3'h1, {2'h0, flag});
      step(10);
      chk("removed", 3'h0, {2'h0, sup});
      presence_sense = 0;
      req_n = 1;
      step(3);
      $display("removal test done");
   endtask
   task automatic t_overtemp();
      activate();
      ot = 1;
      step(3);
      chk("overtemp", 3'h0, {1'h0, sup, alm});
      chk("host oe", 3'h0, hoe);
      ot = 0;
      req_n = 1;
      step(3);
      chk("host oe", 3'h7, hoe);
      $display("overtemp test done");
   endtask
   // Main sequence after a 12-cycle reset
   initial begin
      step(12);
      srst_in = 0;
      step(2);
      t_idle();
      t_active();
      t_chan();
      t_fault();
      t_deact();
      t_removal();
      t_overtemp();
      end_of_test();
   end
   // Watchdog well beyond the expected run
   initial begin
      repeat (3000) @(posedge clk_in);
      miscompares++;
      end_of_test();
   end
endmodule
